/* shared/dcw_pkg.sv */
// package of constants and types for the device configuration words
package dcw_pkg;
   localparam int unsigned WORD_W = 12;
   // programming command codes
   localparam logic [2:0] CMD_NONE = 3'h0;
   localparam logic [2:0] CMD_RD_PRI = 3'h1;
   localparam logic [2:0] CMD_WR_PRI = 3'h2;
   localparam logic [2:0] CMD_RD_EXT = 3'h3;
   localparam logic [2:0] CMD_WR_EXT = 3'h4;
   localparam logic [2:0] CMD_RD_ID = 3'h5;
   localparam logic [2:0] CMD_WR_ID = 3'h6;
   // primary word field positions
   localparam int unsigned BIT_RATE = 11;
   localparam int unsigned BIT_SYNC = 10;
   localparam int unsigned BIT_IOSC_DIS = 7;
   localparam int unsigned BIT_DIV1 = 6;
   localparam int unsigned BIT_SHARED = 5;
   localparam int unsigned BIT_CP_N = 3;
   localparam int unsigned BIT_WDT = 2;
   localparam int unsigned BIT_FOSC1 = 1;
   localparam int unsigned BIT_FOSC0 = 0;
   // erased state of the nonvolatile cells
   localparam logic [11:0] PRI_RESET = 12'hfff;
   localparam logic [11:0] EXT_RESET = 12'hfff;
   // arbitrary neutral part code, not tied to any real part
   localparam logic [11:0] PART_ID_SMALL = 12'h5a3;
   localparam logic [11:0] PART_ID_LARGE = 12'h5a4;
   // scramble key used under code protection
   localparam logic [11:0] SCRAMBLE_KEY = 12'ha5c;
   // divider codes, then the external RC oscillator type code
   localparam logic [1:0] DIV_4MHZ = 2'h0;
   localparam logic [1:0] DIV_1MHZ = 2'h1;
   localparam logic [1:0] DIV_128K = 2'h2;
   localparam logic [1:0] DIV_32K = 2'h3;
   localparam logic [2:0] FOSC_EXT_RC = 3'h7;

   typedef struct packed {
      logic valid;
      logic [2:0] cmd;
      logic [11:0] wdata;
   } dcw_req_s;

   typedef struct packed {
      logic rate_quarter;
      logic sync_bypass;
      logic int_osc_on;
      logic [1:0] osc_div;
      logic [2:0] ext_osc_type;
      logic ext_rc_mode;
      logic code_protect;
      logic watchdog_on;
   } dcw_cfg_s;

   typedef struct packed {
      logic [1:0] small_field_a;
      logic [9:0] small_field_b;
   } dcw_ext_s;
endpackage

/* hw/dcw_primary_decode.sv */
// decode of the primary configuration word into clocking controls
`timescale 1ns/100ps
`default_nettype none
module dcw_primary_decode
(
   // word in
   input wire logic [11:0] i_word,
   // decoded controls
   output dcw_pkg::dcw_cfg_s o_cfg
);
   always_comb
   begin
      o_cfg.rate_quarter = i_word[dcw_pkg::BIT_RATE]; // RULE6
      o_cfg.sync_bypass = i_word[dcw_pkg::BIT_SYNC]; // RULE7
      o_cfg.int_osc_on = ~i_word[dcw_pkg::BIT_IOSC_DIS]; // RULE8
      // bit 5 is shared: divider low bit or type top bit
      if (!i_word[dcw_pkg::BIT_IOSC_DIS])
      begin
         o_cfg.osc_div = {i_word[dcw_pkg::BIT_DIV1],
                          i_word[dcw_pkg::BIT_SHARED]}; // RULE9 RULE10
         o_cfg.ext_osc_type = 3'h0;
      end
      else
      begin
         o_cfg.osc_div = dcw_pkg::DIV_4MHZ;
         o_cfg.ext_osc_type = {i_word[dcw_pkg::BIT_SHARED],
                               i_word[dcw_pkg::BIT_FOSC1],
                               i_word[dcw_pkg::BIT_FOSC0]}; // RULE10 RULE11
      end
      o_cfg.ext_rc_mode = i_word[dcw_pkg::BIT_IOSC_DIS] &&
                          (o_cfg.ext_osc_type == dcw_pkg::FOSC_EXT_RC); // RULE11
      o_cfg.code_protect = ~i_word[dcw_pkg::BIT_CP_N]; // RULE12
      o_cfg.watchdog_on = i_word[dcw_pkg::BIT_WDT]; // RULE13
   end
endmodule
`default_nettype wire

/* hw/dcw_input_sync.sv */
// optional two-flop input synchroniser
`timescale 1ns/100ps
`default_nettype none
module dcw_input_sync #(
   parameter int unsigned WIDTH = 8
)
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   // control
   input wire logic i_bypass,
   // data
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_data
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] out_r;
   logic [WIDTH-1:0] out_nxt;

   // bypass path still registered once so the output comes from a flop
   always_comb
   begin
      out_nxt = i_bypass ? i_async : s2_r; // RULE7
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         s1_r <= '0;
         s2_r <= '0;
         out_r <= '0;
      end
      else if (i_ce)
      begin
         s1_r <= i_async;
         s2_r <= s1_r;
         out_r <= out_nxt;
      end
   end

   assign o_data = out_r;
endmodule
`default_nettype wire

/* hw/dcw_config_words.sv */
// device configuration words: storage, programming access and decode
//
// Function
// RULE1: three 12-bit registers, programmable alongside memory
// RULE2: access only during programming setup
// RULE3: part id read-only, writes ignored
// RULE4: fixed 12-bit part code readable
// RULE5: extended word layout depends on variant
// RULE6: rate bit 1 gives quarter rate
// RULE7: sync bit 0 adds two-flop synchroniser
// RULE8: oscillator disable bit selects external type
// RULE9: divider field selects 4M/1M/128K/32K
// RULE10: bit 5 shared divider/type bit
// RULE11: type field selects oscillator, 111 RC
// RULE12: code protect 0 scrambles readback
// RULE13: watchdog enable bit enables watchdog
// RULE14: values retained, applied from reset onward
`timescale 1ns/100ps
`default_nettype none
module dcw_config_words #(
   parameter bit LARGE_VARIANT = 1'b0,
   parameter int unsigned IN_W = 8
)
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   // programming port
   input wire logic i_prog_mode,
   input wire dcw_pkg::dcw_req_s i_req,
   output logic o_rvalid,
   output logic [11:0] o_rdata,
   // decoded configuration
   output dcw_pkg::dcw_cfg_s o_cfg,
   output logic [1:0] o_ext_a,
   output logic [9:0] o_ext_b,
   output logic o_instr_tick,
   // port inputs
   input wire logic [IN_W-1:0] i_port_pins,
   output logic [IN_W-1:0] o_port_data
);
   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_PROG = 2'b10
   } dcw_state_e;

   dcw_state_e st_r;
   dcw_state_e st_nxt;
   logic pm_s1_r;
   logic pm_s2_r;
   // words model nonvolatile cells: no reset so they survive reset
   logic [11:0] pri_r;
   logic [11:0] pri_nxt;
   logic [11:0] ext_r;
   logic [11:0] ext_nxt;
   logic init_r;
   logic rvalid_r;
   logic rvalid_nxt;
   logic [11:0] rdata_r;
   logic [11:0] rdata_nxt;
   logic [1:0] tick_cnt_r;
   logic [1:0] tick_cnt_nxt;
   logic [11:0] part_id;
   logic access_ok;
   dcw_pkg::dcw_ext_s ext_fields;

   function automatic logic [11:0] readback(input logic [11:0] w,
                                            input logic prot);
      readback = prot ? (w ^ dcw_pkg::SCRAMBLE_KEY) : w;
   endfunction

   assign part_id = LARGE_VARIANT ? dcw_pkg::PART_ID_LARGE
                                  : dcw_pkg::PART_ID_SMALL; // RULE4

   // programming-mode pin passes two flops before use
   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         pm_s1_r <= 1'b0;
         pm_s2_r <= 1'b0;
      end
      else if (i_ce)
      begin
         pm_s1_r <= i_prog_mode;
         pm_s2_r <= pm_s1_r;
      end
   end

   always_comb
   begin
      case (st_r)
         ST_RUN: st_nxt = pm_s2_r ? ST_PROG : ST_RUN;
         ST_PROG: st_nxt = pm_s2_r ? ST_PROG : ST_RUN;
         default: st_nxt = ST_RUN;
      endcase
   end

   assign access_ok = (st_r == ST_PROG) && i_req.valid; // RULE2

   always_comb
   begin
      pri_nxt = pri_r;
      ext_nxt = ext_r;
      rvalid_nxt = 1'b0;
      rdata_nxt = rdata_r;
      // an unknown flag at power-up must also land on the erased load
      if (init_r)
      begin
         if (access_ok) // RULE1
         begin
            if (i_req.cmd == dcw_pkg::CMD_WR_PRI)
            begin
               pri_nxt = i_req.wdata;
            end
            else if (i_req.cmd == dcw_pkg::CMD_WR_EXT)
            begin
               ext_nxt = i_req.wdata;
            end
            else if (i_req.cmd == dcw_pkg::CMD_RD_PRI)
            begin
               rvalid_nxt = 1'b1;
               rdata_nxt = readback(pri_r, o_cfg.code_protect); // RULE12
            end
            else if (i_req.cmd == dcw_pkg::CMD_RD_EXT)
            begin
               rvalid_nxt = 1'b1;
               rdata_nxt = readback(ext_r, o_cfg.code_protect); // RULE12
            end
            else if (i_req.cmd == dcw_pkg::CMD_RD_ID)
            begin
               rvalid_nxt = 1'b1;
               rdata_nxt = part_id; // RULE3 RULE4
            end
            // a write to the id word falls through and changes nothing
         end
      end
      else
      begin
         pri_nxt = dcw_pkg::PRI_RESET;
         ext_nxt = dcw_pkg::EXT_RESET;
      end
   end

   // nonvolatile words: loaded once after first clock, kept thereafter
   always_ff @(posedge i_sys_clk)
   begin
      if (i_ce)
      begin
         pri_r <= pri_nxt;
         ext_r <= ext_nxt;
      end
   end

   // init flag models the one-time erased state, not a reload on reset
   always_ff @(posedge i_sys_clk)
   begin
      if (i_ce)
      begin
         init_r <= 1'b1;
      end
   end

   always_comb
   begin
      if (!o_cfg.rate_quarter)
      begin
         tick_cnt_nxt = 2'h0;
      end
      else
      begin
         tick_cnt_nxt = 2'(tick_cnt_r + 2'h1); // RULE6
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_r <= ST_RUN;
         rvalid_r <= 1'b0;
         rdata_r <= 12'h000;
         tick_cnt_r <= 2'h0;
      end
      else if (i_ce)
      begin
         st_r <= st_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         tick_cnt_r <= tick_cnt_nxt;
      end
   end

   assign o_rvalid = rvalid_r;
   assign o_rdata = rdata_r;
   assign o_instr_tick = i_ce && (!o_cfg.rate_quarter ||
                                  tick_cnt_r == 2'h3); // RULE6

   // the variant picks the field split of the extended word
   always_comb
   begin
      if (LARGE_VARIANT)
      begin
         ext_fields = {ext_r[1:0], ext_r[11:2]}; // RULE5
      end
      else
      begin
         ext_fields = ext_r; // RULE5
      end
   end

   assign o_ext_a = ext_fields.small_field_a;
   assign o_ext_b = ext_fields.small_field_b;

   // applied combinationally so stored values act from reset on
   dcw_primary_decode u_dec
   (
      .i_word(init_r ? pri_r : dcw_pkg::PRI_RESET), // RULE14
      .o_cfg(o_cfg)
   );

   dcw_input_sync #(
      .WIDTH(IN_W)
   ) u_sync
   (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .i_ce(i_ce),
      .i_bypass(o_cfg.sync_bypass),
      .i_async(i_port_pins),
      .o_data(o_port_data)
   );

   a_id_readonly: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (init_r && i_ce && access_ok && i_req.cmd == dcw_pkg::CMD_WR_ID)
      |=> (pri_r == $past(pri_r) && ext_r == $past(ext_r)))
      else $error("id write altered a word"); // RULE3

   a_id_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_ce && access_ok && i_req.cmd == dcw_pkg::CMD_RD_ID)
      |=> (o_rvalid && o_rdata == part_id))
      else $error("id readback wrong"); // RULE4

   a_no_run_write: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (init_r && i_ce && st_r == ST_RUN) |=> (pri_r == $past(pri_r)))
      else $error("word changed outside programming"); // RULE2

   a_no_run_read: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_ce && st_r == ST_RUN) |=> !o_rvalid)
      else $error("read answered outside programming"); // RULE2

   a_write_pri: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (init_r && i_ce && access_ok && i_req.cmd == dcw_pkg::CMD_WR_PRI)
      |=> (pri_r == $past(i_req.wdata)))
      else $error("primary write lost"); // RULE1

   a_scramble_rd: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (init_r && i_ce && access_ok && i_req.cmd == dcw_pkg::CMD_RD_PRI)
      |=> (o_rdata == (pri_r[dcw_pkg::BIT_CP_N] ? pri_r
                       : (pri_r ^ dcw_pkg::SCRAMBLE_KEY))))
      else $error("readback protection wrong"); // RULE12

   a_quarter_rate: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_ce && o_cfg.rate_quarter && o_instr_tick) ##1
      (i_ce && o_cfg.rate_quarter) |-> !o_instr_tick)
      else $error("quarter rate ticks too often"); // RULE6

   a_shared_bit: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (init_r && pri_r[dcw_pkg::BIT_IOSC_DIS]) |->
      (o_cfg.ext_osc_type[2] == pri_r[dcw_pkg::BIT_SHARED] && !o_cfg.int_osc_on))
      else $error("shared bit misrouted"); // RULE10 RULE8

   a_watchdog_en: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      init_r |-> (o_cfg.watchdog_on == pri_r[dcw_pkg::BIT_WDT]))
      else $error("watchdog enable wrong"); // RULE13
endmodule
`default_nettype wire

/* tb/dcw_prog_model.sv */
// external programmer model issuing programming commands
`timescale 1ns/100ps
`default_nettype none
module dcw_prog_model
(
   // clock
   input wire logic i_sys_clk,
   // programming port
   output logic o_prog_mode,
   output dcw_pkg::dcw_req_s o_req,
   input wire logic i_rvalid,
   input wire logic [11:0] i_rdata
);
   initial
   begin
      o_prog_mode = 1'b0;
      o_req = '0;
   end
   // mode pin is synced inside, so allow the sync delay
   task automatic set_mode(input logic m);
      @(negedge i_sys_clk);
      o_prog_mode = m;
      repeat (4) @(negedge i_sys_clk);
   endtask
   // one-cycle command, then a bounded look for the read answer
   task automatic send(input logic [2:0] cmd, input logic [11:0] wd,
      output logic got, output logic [11:0] rd);
      int n;
      got = 1'b0;
      rd = '0;
      @(negedge i_sys_clk);
      o_req = {1'b1, cmd, wd};
      @(negedge i_sys_clk);
      o_req = {1'b0, dcw_pkg::CMD_NONE, ~wd};
      for (n = 0; n < 4 && !got; n++)
      begin
         got = (i_rvalid === 1'b1);
         rd = i_rdata;
         if (!got)
            @(negedge i_sys_clk);
      end
   endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking testbench for the configuration words block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rstn;
   logic ce;
   logic pm;
   dcw_pkg::dcw_req_s req;
   logic rv;
   logic [11:0] rd;
   dcw_pkg::dcw_cfg_s cfg;
   logic [1:0] ea;
   logic [9:0] eb;
   logic tick;
   logic [7:0] pins;
   logic [7:0] pdat;
   int errors = 0;
   int total_checks = 0;
   logic [11:0] rows [12] = '{12'h00c, 12'h02c, 12'h848, 12'h460,
      12'h088, 12'h089, 12'h08a, 12'h48b, 12'h0a8, 12'h0a9, 12'h8aa,
      12'h0a3};
   always #5 clk = ~clk;
   dcw_config_words u_dut (
      .i_sys_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_prog_mode(pm),
      .i_req(req), .o_rvalid(rv), .o_rdata(rd), .o_cfg(cfg),
      .o_ext_a(ea), .o_ext_b(eb), .o_instr_tick(tick),
      .i_port_pins(pins), .o_port_data(pdat));
   dcw_prog_model u_prog (.i_sys_clk(clk), .o_prog_mode(pm), .o_req(req),
      .i_rvalid(rv), .i_rdata(rd));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk_word(string nm, logic [11:0] e, logic [11:0] g);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // fields that the other oscillator mode does not use are masked
   task automatic chk_cfg(logic [11:0] w);
      dcw_pkg::dcw_cfg_s e;
      dcw_pkg::dcw_cfg_s g;
      e = {w[11], w[10], ~w[7], w[6:5], w[5], w[1:0],
         w[7] & (w[5] & (&w[1:0])), ~w[3], w[2]};
      g = cfg;
      if (w[7])
         {e.osc_div, g.osc_div} = '0;
      else
         {e.ext_osc_type, e.ext_rc_mode, g.ext_osc_type, g.ext_rc_mode} = '0;
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("BAD cfg exp %h got %h", e, g);
      end
   endtask
   function automatic logic [11:0] seen(logic [11:0] v, logic [11:0] p);
      return p[3] ? v : v ^ dcw_pkg::SCRAMBLE_KEY;
   endfunction
   task automatic rd_word(logic [2:0] c, logic [11:0] e, logic want);
      logic got;
      logic [11:0] d;
      u_prog.send(c, 12'h000, got, d);
      chk_word("rvalid", {11'h0, want}, {11'h0, got});
      if (want)
         chk_word("rdata", e, d);
   endtask
   task automatic wr_word(logic [2:0] c, logic [11:0] w);
      logic got;
      logic [11:0] d;
      u_prog.send(c, w, got, d);
      chk_word("wr_rvalid", 12'h000, {11'h0, got});
   endtask
   task automatic clk_pins(logic [11:0] w, int et, int el);
      int n;
      int t;
      t = 0;
      for (n = 0; n < 40; n++)
      begin
         @(negedge clk);
         t += (tick === 1'b1);
      end
      chk_word("ticks", et[11:0], t[11:0]);
      pins = ~pins;
      n = 0;
      while (pdat !== pins && n < 8)
      begin
         @(negedge clk);
         n++;
      end
      chk_word("latency", el[11:0], n[11:0]);
   endtask
   initial
   begin
      #100000;
      errors++;
      stop_test();
   end
   initial
   begin
      rstn = 1'b0;
      ce = 1'b1;
      pins = 8'h00;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      u_prog.set_mode(1'b1);
      rd_word(dcw_pkg::CMD_RD_PRI, 12'hfff, 1'b1);
      rd_word(dcw_pkg::CMD_RD_EXT, 12'hfff, 1'b1);
      rd_word(dcw_pkg::CMD_RD_ID, dcw_pkg::PART_ID_SMALL, 1'b1);
      $display("test erased done");
      foreach (rows[i])
      begin
         wr_word(dcw_pkg::CMD_WR_PRI, rows[i]);
         rd_word(dcw_pkg::CMD_RD_PRI, seen(rows[i], rows[i]), 1'b1);
         chk_cfg(rows[i]);
      end
      $display("test rows done");
      wr_word(dcw_pkg::CMD_WR_PRI, 12'h008);
      clk_pins(12'h008, 40, 3);
      wr_word(dcw_pkg::CMD_WR_PRI, 12'hc08);
      clk_pins(12'hc08, 10, 1);
      $display("test clocking done");
      wr_word(dcw_pkg::CMD_WR_EXT, 12'h6b5);
      rd_word(dcw_pkg::CMD_RD_EXT, 12'h6b5, 1'b1);
      chk_word("ext", 12'h6b5, {ea, eb});
      wr_word(dcw_pkg::CMD_WR_ID, 12'h000);
      rd_word(dcw_pkg::CMD_RD_ID, dcw_pkg::PART_ID_SMALL, 1'b1);
      $display("test ext id done");
      // let the last read answer drop before freezing the block
      @(negedge clk);
      ce = 1'b0;
      wr_word(dcw_pkg::CMD_WR_PRI, 12'h000);
      clk_pins(12'hc08, 0, 8);
      ce = 1'b1;
      rd_word(dcw_pkg::CMD_RD_PRI, 12'hc08, 1'b1);
      $display("test enable done");
      u_prog.set_mode(1'b0);
      wr_word(dcw_pkg::CMD_WR_PRI, 12'h000);
      rd_word(dcw_pkg::CMD_RD_PRI, 12'h000, 1'b0);
      u_prog.set_mode(1'b1);
      rd_word(dcw_pkg::CMD_RD_PRI, 12'hc08, 1'b1);
      $display("test locked done");
      @(negedge clk);
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      chk_word("rst_rvalid", 12'h000, {11'h0, rv});
      rstn = 1'b1;
      u_prog.set_mode(1'b1);
      rd_word(dcw_pkg::CMD_RD_PRI, 12'hc08, 1'b1);
      chk_cfg(12'hc08);
      $display("test retain done");
      stop_test();
   end
endmodule
`default_nettype wire
